// *** bench/asce_line_peer.sv ***
// Serial line partner: sends and decodes frames paced by the 16x tick
`timescale 1ns/1ps
module asce_line_peer (
    input  wire i_clk_sys,
    input  wire i_tick,
    input  wire i_line,
    output reg  o_line
);
    int         tcnt = 0;
    int         nbits = 8;
    int         pen = 0;
    logic [9:0] rxq[$];
    // ****************
    // Tick pacing
    // ****************
    always @(posedge i_clk_sys) begin
        tcnt <= tcnt + i_tick;
    end
    task automatic ticks(input int n);
        int t;
        t = tcnt + n;
        wait (tcnt == t);
        #2;
    endtask
    // Idle line rests at mark, as with a pull-up
    task automatic send(input logic [11:0] f, input int n, input int w);
        for (int i = 0; i < n; i++) begin
            o_line = f[i];
            ticks(w);
        end
        o_line = 1'b1;
    endtask
    // Mid-bit sampling keeps clear of the edge where the line moves
    initial begin
        logic [9:0] v;
        o_line = 1'b1;
        forever begin
            @(negedge i_line);
            ticks(8);
            if (i_line == 1'b0) begin
                v = '0;
                for (int i = 0; i < nbits + pen + 1; i++) begin
                    ticks(16);
                    v[i] = i_line;
                end
                rxq.push_back(v);
            end
        end
    end
endmodule

// *** bench/asce_monitor.sv ***
// Concurrent checks on the host port and line pins of the element
`timescale 1ns/1ps
module asce_monitor (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_master_clear,
    input wire i_select_high_a,
    input wire i_select_high_b,
    input wire i_select_low_n,
    input wire i_select_latch_strobe_n,
    input wire i_read_strobe,
    input wire i_read_strobe_n,
    input wire o_data_oe,
    input wire o_transceiver_turn_n,
    input wire o_selected_flag_out,
    input wire o_serial_tx_out,
    input wire o_irq_out
);
    // ****************
    // Checks
    // ****************
    wire rd  = i_read_strobe | ~i_read_strobe_n;
    wire sel = i_select_high_a & i_select_high_b & ~i_select_low_n;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_read_turn;
        rd [*4] ##1 (rd && o_selected_flag_out) |-> !o_transceiver_turn_n;
    endproperty
    a_turn_inverse: assert property (o_transceiver_turn_n == !o_data_oe)
        else $error("turn pin not inverse of enable");
    a_tx_mark: assert property ($rose(i_nrst) |-> o_serial_tx_out)
        else $error("serial out low after reset");
    a_irq_quiet: assert property ($rose(i_nrst) |-> !o_irq_out)
        else $error("interrupt high after reset");
    a_oe_cause: assert property ($rose(o_data_oe) |-> $past(rd, 2))
        else $error("bus driven without read");
    a_oe_release: assert property (!rd [*4] |-> !o_data_oe)
        else $error("bus driven after read");
    a_read_turn: assert property (p_read_turn)
        else $error("turn pin high during read");
    a_sel_cause: assert property ($rose(o_selected_flag_out) |-> $past(sel, 2))
        else $error("selected without selects");
    a_desel_drop: assert property ((!sel && !i_select_latch_strobe_n) [*6]
        |-> !o_selected_flag_out) else $error("selected flag stuck");
    a_mclr_idle: assert property (i_master_clear [*5] |-> o_serial_tx_out && !o_irq_out)
        else $error("master clear left line or irq active");
    c_read: cover property ($rose(o_data_oe));
    c_frame: cover property ($fell(o_serial_tx_out));
    c_irq: cover property ($rose(o_irq_out));
endmodule
bind asce_top asce_monitor u_mon (.i_clk_sys, .i_nrst, .i_master_clear, .i_select_high_a,
    .i_select_high_b, .i_select_low_n, .i_select_latch_strobe_n, .i_read_strobe,
    .i_read_strobe_n, .o_data_oe, .o_transceiver_turn_n, .o_selected_flag_out,
    .o_serial_tx_out, .o_irq_out);

// *** bench/tb_top.sv ***
// Self-checking bench for the serial communications element
`timescale 1ns/1ps
`include "asce_consts.vh"
module tb_top;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       mclr = 1'b0;
    logic [2:0] cs = 3'b000;
    logic       ads_n = 1'b0;
    logic [2:0] ra = 3'h0;
    logic [3:0] stb = 4'b0101;
    logic [7:0] wd = 8'h00;
    logic [31:0] seed = 32'h04579338;
    wire  [7:0] rdat;
    wire        oe, turn_n, self, bclk, txo, rxi, irq;
    int         n_fail = 0;
    int         total_checks = 0;
    asce_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_master_clear(mclr),
        .i_select_high_a(cs[2]), .i_select_high_b(cs[1]), .i_select_low_n(cs[0]),
        .i_select_latch_strobe_n(ads_n), .i_reg_sel_0(ra[0]), .i_reg_sel_1(ra[1]),
        .i_reg_sel_2(ra[2]), .i_write_strobe(stb[3]), .i_write_strobe_n(stb[2]),
        .i_read_strobe(stb[1]), .i_read_strobe_n(stb[0]), .i_data(wd), .o_data(rdat),
        .o_data_oe(oe), .o_transceiver_turn_n(turn_n), .o_selected_flag_out(self),
        .o_tx_bit_clock_out(bclk), .i_rx_clock_in(bclk), .i_serial_rx_in(rxi),
        .o_serial_tx_out(txo), .o_irq_out(irq));
    asce_line_peer peer (.i_clk_sys(clk), .i_tick(bclk), .i_line(txo), .o_line(rxi));
    initial forever #12.5 clk = ~clk;
    // ****************
    // Host tasks
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkf(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t frame %h expected %h", $time, g, e);
        end
    endtask
    // Address strobe low makes selects transparent unless lat asks to latch
    task automatic acc(input bit w, input [2:0] a, input [7:0] d, input [2:0] c,
                       input bit lat, output logic [7:0] q);
        int k;
        bit p;
        p = (rnd() & 1) != 0;
        cs = c;
        ra = a;
        wd = d;
        ads_n = 1'b0;
        cyc(4);
        k = 0;
        while (c == 3'b110 && self !== 1'b1 && k++ < 20) cyc(1);
        if (lat) begin
            ads_n = 1'b1;
            cyc(3);
            cs = 3'b000;
            ra = ~a;
        end
        stb = w ? (p ? 4'b1101 : 4'b0001) : (p ? 4'b0111 : 4'b0100);
        k = 0;
        while (!w && oe !== 1'b1 && k++ < 8) cyc(1);
        cyc(w ? 4 : 1);
        q = (oe === 1'b1) ? rdat : 8'hee;
        stb = 4'b0101;
        cyc(1);
        cs = 3'b000;
        ads_n = 1'b0;
        cyc(6);
    endtask
    task automatic wr(input [2:0] a, input [7:0] d);
        logic [7:0] q;
        acc(1, a, d, 3'b110, (rnd() & 1) != 0, q);
    endtask
    task automatic rchk(input [2:0] a, input [7:0] e);
        logic [7:0] q;
        acc(0, a, 8'h00, 3'b110, (rnd() & 1) != 0, q);
        chk8(q, e);
    endtask
    task automatic wait_lsr(input logic [7:0] m);
        logic [7:0] q;
        int k;
        k = 0;
        do begin
            acc(0, `ASCE_REG_LSR, 8'h00, 3'b110, 0, q);
            k++;
        end while ((q & m) !== m && k < 300);
        chk8(q & m, m);
    endtask
    task automatic wait_q();
        int k;
        k = 0;
        while (peer.rxq.size() == 0 && k++ < 2000) cyc(1);
    endtask
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        logic [7:0] q, b;
        logic [11:0] f;
        logic par;
        logic [7:0] eq[$];
        logic [7:0] lx[4] = '{8'h61, 8'h65, 8'h79, 8'h63};
        int n, k;
        cyc(10);
        nrst = 1'b1;
        cyc(3);
        chk8({7'h0, txo}, 8'h01);
        rchk(`ASCE_REG_LSR, 8'h60);
        rchk(`ASCE_REG_IIR, 8'h01);
        for (int i = 0; i < 6; i++) begin
            acc(1, `ASCE_REG_LCR, 8'h1b, 3'(i), 0, q);
            acc(0, `ASCE_REG_LCR, 8'h00, 3'(i), 0, q);
            chk8(q, 8'hee);
        end
        acc(0, `ASCE_REG_LCR, 8'h00, 3'b111, 0, q);
        chk8(q, 8'hee);
        rchk(`ASCE_REG_LCR, 8'h00);
        wr(3'h7, 8'h5a);
        rchk(3'h7, 8'h5a);
        rchk(`ASCE_REG_MSR, 8'h00);
        for (int d = 1; d < 4; d += 2) begin
            wr(`ASCE_REG_LCR, 8'h80);
            wr(`ASCE_REG_DATA, 8'(d));
            wr(`ASCE_REG_IER, 8'h00);
            rchk(`ASCE_REG_DATA, 8'(d));
            wr(`ASCE_REG_LCR, 8'h00);
            k = 0;
            while (bclk !== 1'b1 && k++ < 50) cyc(1);
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (bclk !== 1'b1 && n < 50);
            chk8(8'(n), 8'(d));
        end
        for (int c = 0; c < 12; c++) begin
            n = 5 + c % 4;
            k = c / 4;
            peer.nbits = n;
            peer.pen = (k != 0);
            b = 8'(rnd()) & 8'((1 << n) - 1);
            par = (k == 2) ? ^b : ~^b;
            wr(`ASCE_REG_LCR, 8'((n - 5) | (c[2] << 2) | ((k != 0) << 3) | ((k == 2) << 4)));
            wr(`ASCE_REG_DATA, b);
            wait_q();
            chkf(peer.rxq.pop_front(), 10'(b | ((k != 0 && par) << n) | (1 << (n + peer.pen))));
            wait_lsr(8'h40);
        end
        wr(`ASCE_REG_LCR, 8'h1a);
        wr(`ASCE_REG_IER, 8'h04);
        for (int e = 0; e < 4; e++) begin
            b = (e == 2) ? 8'h00 : 8'(rnd()) & 8'h7f;
            f = (e == 2) ? 12'h000 : 12'((b << 1) | ((^b ^ (e == 1)) << 8) | 12'h200);
            peer.send(f, 10, 16);
            if (e == 3) peer.send(f, 10, 16);
            chk8({7'h0, irq}, (e == 0) ? 8'h00 : 8'h01);
            rchk(`ASCE_REG_IIR, (e == 0) ? 8'h01 : 8'h06);
            rchk(`ASCE_REG_LSR, lx[e]);
            rchk(`ASCE_REG_DATA, b);
        end
        peer.send(12'h000, 1, 4);
        peer.send(12'hfff, 12, 16);
        rchk(`ASCE_REG_LSR, 8'h60);
        wr(`ASCE_REG_MCR, 8'h10);
        wr(`ASCE_REG_IER, 8'h01);
        b = 8'(rnd()) & 8'h7f;
        wr(`ASCE_REG_DATA, b);
        wait_lsr(8'h01);
        chk8({7'h0, txo}, 8'h01);
        chk8({7'h0, irq}, 8'h01);
        rchk(`ASCE_REG_IIR, 8'h04);
        rchk(`ASCE_REG_DATA, b);
        chk8({7'h0, irq}, 8'h00);
        wr(`ASCE_REG_MCR, 8'h00);
        wr(`ASCE_REG_IER, 8'h00);
        wr(`ASCE_REG_LCR, 8'h03);
        peer.nbits = 8;
        peer.pen = 0;
        // One word in the shifter plus four held; the sixth is dropped
        for (int i = 0; i < 6; i++) begin
            b = 8'(rnd());
            if (i < 5) eq.push_back(b);
            wr(`ASCE_REG_DATA, b);
        end
        rchk(`ASCE_REG_LSR, 8'h00);
        wait_lsr(8'h40);
        for (int i = 0; i < 5; i++) chkf(peer.rxq.pop_front(), {2'b01, eq.pop_front()});
        chk8(8'(peer.rxq.size()), 8'h00);
        wr(`ASCE_REG_IER, 8'h02);
        chk8({7'h0, irq}, 8'h01);
        rchk(`ASCE_REG_IIR, 8'h02);
        chk8({7'h0, irq}, 8'h00);
        wr(`ASCE_REG_LCR, 8'h43);
        chk8({7'h0, txo}, 8'h00);
        mclr = 1'b1;
        cyc(6);
        mclr = 1'b0;
        cyc(4);
        chk8({7'h0, txo}, 8'h01);
        rchk(`ASCE_REG_LCR, 8'h00);
        rchk(`ASCE_REG_IER, 8'h00);
        rchk(`ASCE_REG_LSR, 8'h60);
        close_out();
    end
    // Whole run needs some 14k cycles; this cuts a hang short
    initial begin
        #1500000;
        n_fail++;
        close_out();
    end
endmodule

// *** inc/asce_consts.vh ***
// Constants for the asynchronous serial communications element
`ifndef ASCE_CONSTS_VH
`define ASCE_CONSTS_VH
// Register select codes
`define ASCE_REG_DATA  3'h0
`define ASCE_REG_IER   3'h1
`define ASCE_REG_IIR   3'h2
`define ASCE_REG_LCR   3'h3
`define ASCE_REG_MCR   3'h4
`define ASCE_REG_LSR   3'h5
`define ASCE_REG_MSR   3'h6
// Line and modem control fields
`define ASCE_LCR_STOP  2
`define ASCE_LCR_PEN   3
`define ASCE_LCR_EPS   4
`define ASCE_LCR_BRK   6
`define ASCE_LCR_DIVISOR_ACCESS_BIT  7
`define ASCE_MCR_LOOP  4
// Line status fields
`define ASCE_LSR_DR    0
`define ASCE_LSR_OE    1
`define ASCE_LSR_PE    2
`define ASCE_LSR_FE    3
`define ASCE_LSR_BI    4
`define ASCE_LSR_THRE  5
`define ASCE_LSR_TEMT  6
// Interrupt enable fields
`define ASCE_IER_RDA   0
`define ASCE_IER_THRE  1
`define ASCE_IER_RLS   2
`define ASCE_IER_MS    3
// Reset values
`define ASCE_RST_BYTE  8'h00
`define ASCE_RST_IIR   8'h01
`define ASCE_RST_DIV   16'h0000
// Timing in 16x ticks
`define ASCE_TICKS_BIT   6'h10
`define ASCE_TICKS_HALF  6'h08
`define ASCE_TICKS_1P5   6'h18
`define ASCE_TICKS_2     6'h20
// Start confirm count, reckoned from the tick that saw the line low
`define ASCE_RX_CONFIRM  4'h6
`define ASCE_FIFO_DEPTH  4
`endif

// *** rtl/asce_top.v ***
// Serial communications element: host port, baud generator, transmitter, receiver
`timescale 1ns/1ps
`include "asce_consts.vh"

// ****************************************
// Transmit holding FIFO
// ****************************************
module asce_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `ASCE_FIFO_DEPTH,
    parameter AW    = 2
) (
    input  wire             i_clk_sys,
    input  wire             i_nrst,
    input  wire             i_clear,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            push = i_in_valid && o_in_ready;
    wire            pop  = o_out_valid && i_out_ready;
    assign o_in_ready  = (count != DEPTH);
    assign o_out_valid = (count != 0);
    assign o_out_data  = mem[rptr];
    always @(posedge i_clk_sys) begin
        if (push)
            mem[wptr] <= i_in_data;
    end
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr  <= {AW{1'b0}};
            rptr  <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (i_clear) begin
            wptr  <= {AW{1'b0}};
            rptr  <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ****************************************
// Top level
// ****************************************
module asce_top (
    input  wire       i_clk_sys,
    input  wire       i_nrst,
    input  wire       i_master_clear,
    input  wire       i_select_high_a,
    input  wire       i_select_high_b,
    input  wire       i_select_low_n,
    input  wire       i_select_latch_strobe_n,
    input  wire       i_reg_sel_0,
    input  wire       i_reg_sel_1,
    input  wire       i_reg_sel_2,
    input  wire       i_write_strobe,
    input  wire       i_write_strobe_n,
    input  wire       i_read_strobe,
    input  wire       i_read_strobe_n,
    input  wire [7:0] i_data,
    output reg  [7:0] o_data,
    output wire       o_data_oe,
    output wire       o_transceiver_turn_n,
    output reg        o_selected_flag_out,
    output reg        o_tx_bit_clock_out,
    input  wire       i_rx_clock_in,
    input  wire       i_serial_rx_in,
    output wire       o_serial_tx_out,
    output wire       o_irq_out
);
    localparam S_IDLE = 5'h01, S_START = 5'h02, S_DATA = 5'h04, S_PAR = 5'h08, S_STOP = 5'h10;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [11:0] pin_raw = {i_master_clear, i_select_high_a, i_select_high_b, i_select_low_n,
                           i_select_latch_strobe_n, i_reg_sel_2, i_reg_sel_1, i_reg_sel_0,
                           i_write_strobe, i_write_strobe_n, i_read_strobe, i_read_strobe_n};
    reg  [11:0] pin_m;
    reg  [11:0] pin_s;
    reg  [1:0]  rx_m;
    reg  [1:0]  rx_s;
    reg         rclk_d;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_m  <= 12'h1c5;
            pin_s  <= 12'h1c5;
            rx_m   <= 2'h2;
            rx_s   <= 2'h2;
            rclk_d <= 1'b0;
        end else begin
            pin_m  <= pin_raw;
            pin_s  <= pin_m;
            rx_m   <= {i_serial_rx_in, i_rx_clock_in};
            rx_s   <= rx_m;
            rclk_d <= rx_s[0];
        end
    end
    wire mclr = pin_s[11];

    // ****************************************
    // Select latching and strobes
    // ****************************************
    reg  [2:0] addr;
    reg        cs_ok;
    reg        wr_d;
    reg        rd_d;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            addr  <= 3'h0;
            cs_ok <= 1'b0;
        end else if (!pin_s[7]) begin
            addr  <= pin_s[6:4];
            cs_ok <= pin_s[10] && pin_s[9] && !pin_s[8];
        end
    end
    wire wr_act = cs_ok && (pin_s[3] || !pin_s[2]);
    wire rd_act = cs_ok && (pin_s[1] || !pin_s[0]);
    wire wr_go  = wr_act && !wr_d;
    wire rd_go  = rd_act && !rd_d;
    assign o_data_oe            = rd_act;
    assign o_transceiver_turn_n = !rd_act;

    // ****************************************
    // Control registers
    // ****************************************
    reg  [7:0]  lcr;
    reg  [7:0]  ier;
    reg  [7:0]  mcr;
    reg  [7:0]  scratch;
    reg  [15:0] divisor;
    wire        divisor_access_bit = lcr[`ASCE_LCR_DIVISOR_ACCESS_BIT];
    wire        loop = mcr[`ASCE_MCR_LOOP];
    wire        thr_wr = wr_go && addr == `ASCE_REG_DATA && !divisor_access_bit;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            lcr <= `ASCE_RST_BYTE;
            ier <= `ASCE_RST_BYTE;
            mcr <= `ASCE_RST_BYTE;
            scratch <= `ASCE_RST_BYTE;
            divisor <= `ASCE_RST_DIV;
            wr_d <= 1'b0;
            rd_d <= 1'b0;
            o_selected_flag_out <= 1'b0;
        end else begin
            wr_d <= wr_act;
            rd_d <= rd_act;
            o_selected_flag_out <= cs_ok;
            if (mclr) begin
                lcr <= `ASCE_RST_BYTE;
                ier <= `ASCE_RST_BYTE;
                mcr <= `ASCE_RST_BYTE;
            end else if (wr_go) begin
                case (addr)
                    `ASCE_REG_DATA: if (divisor_access_bit) divisor[7:0] <= i_data;
                    `ASCE_REG_IER: begin
                        if (divisor_access_bit)
                            divisor[15:8] <= i_data;
                        else
                            ier <= {4'h0, i_data[3:0]};
                    end
                    `ASCE_REG_LCR: lcr <= i_data;
                    `ASCE_REG_MCR: mcr <= {3'h0, i_data[4:0]};
                    3'h7: scratch <= i_data;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Baud generator
    // ****************************************
    reg [15:0] bcnt;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            bcnt <= 16'h0000;
            o_tx_bit_clock_out <= 1'b0;
        end else if (divisor == 16'h0000) begin
            bcnt <= 16'h0000;
            o_tx_bit_clock_out <= 1'b0;
        end else if (bcnt <= 16'h0001) begin
            bcnt <= divisor;
            o_tx_bit_clock_out <= 1'b1;
        end else begin
            bcnt <= bcnt - 16'h0001;
            o_tx_bit_clock_out <= 1'b0;
        end
    end
    wire ttick = o_tx_bit_clock_out;
    wire rtick = loop ? ttick : (rx_s[0] && !rclk_d);

    // ****************************************
    // Transmitter
    // ****************************************
    wire       ff_valid;
    wire       ff_ready;
    wire [7:0] ff_data;
    reg  [4:0] tst;
    reg  [5:0] tcnt;
    reg  [2:0] tbit;
    reg  [7:0] tsh;
    reg        tpar;
    reg        tline;
    wire [2:0] nbits = {1'b1, lcr[1:0]};  // 5..8 data bits less one
    wire       tpop  = (tst == S_IDLE) && ttick;
    asce_fifo #(.WIDTH(8), .DEPTH(`ASCE_FIFO_DEPTH), .AW(2)) u_txf (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_clear    (mclr),
        .i_in_valid (thr_wr),
        .o_in_ready (ff_ready),
        .i_in_data  (i_data),
        .o_out_valid(ff_valid),
        .i_out_ready(tpop),
        .o_out_data (ff_data)
    );
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            tst <= S_IDLE;
            tcnt <= 6'h00;
            tbit <= 3'h0;
            tsh <= 8'h00;
            tpar <= 1'b0;
            tline <= 1'b1;
        end else if (mclr) begin
            tst <= S_IDLE;
            tline <= 1'b1;
        end else if (ttick) begin
            tcnt <= tcnt - 6'h01;
            case (tst)
                S_IDLE: begin
                    tline <= 1'b1;
                    if (ff_valid) begin
                        tst <= S_START;
                        tsh <= ff_data;
                        tpar <= 1'b0;
                        tline <= 1'b0;
                        tcnt <= `ASCE_TICKS_BIT - 6'h01;
                    end
                end
                S_START, S_DATA: if (tcnt == 6'h00) begin
                    if (tst == S_DATA && tbit == nbits) begin
                        tst <= lcr[`ASCE_LCR_PEN] ? S_PAR : S_STOP;
                        tline <= lcr[`ASCE_LCR_PEN] ? (tpar ^ !lcr[`ASCE_LCR_EPS]) : 1'b1;
                        tcnt <= !lcr[`ASCE_LCR_PEN] && lcr[`ASCE_LCR_STOP] ?
                                ((lcr[1:0] == 2'h0) ? `ASCE_TICKS_1P5 : `ASCE_TICKS_2) - 6'h01 :
                                `ASCE_TICKS_BIT - 6'h01;
                    end else begin
                        tbit <= (tst == S_START) ? 3'h0 : tbit + 3'h1;
                        tst <= S_DATA;
                        tline <= tsh[0];
                        tpar <= tpar ^ tsh[0];
                        tsh <= {1'b0, tsh[7:1]};
                        tcnt <= `ASCE_TICKS_BIT - 6'h01;
                    end
                end
                S_PAR: if (tcnt == 6'h00) begin
                    tst <= S_STOP;
                    tline <= 1'b1;
                    tcnt <= !lcr[`ASCE_LCR_STOP] ? `ASCE_TICKS_BIT - 6'h01 :
                            ((lcr[1:0] == 2'h0) ? `ASCE_TICKS_1P5 : `ASCE_TICKS_2) - 6'h01;
                end
                S_STOP: if (tcnt == 6'h00) tst <= S_IDLE;
                default: tst <= S_IDLE;
            endcase
        end
    end
    wire txd = tline && !lcr[`ASCE_LCR_BRK];
    assign o_serial_tx_out = loop ? 1'b1 : txd;

    // ****************************************
    // Receiver
    // ****************************************
    wire       rxd = loop ? txd : rx_s[1];
    reg  [4:0] rst_q;
    reg  [3:0] rcnt;
    reg  [2:0] rbit;
    reg  [7:0] rsh;
    reg  [7:0] rbr;
    reg        rpar;
    reg        rperr;
    reg        rhigh;
    reg  [4:0] lsr_f;  // BI FE PE OE DR
    reg        thre_pend;
    wire       rb_rd  = rd_go && addr == `ASCE_REG_DATA && !divisor_access_bit;
    wire       lsr_rd = rd_go && addr == `ASCE_REG_LSR;
    wire       rdone  = rtick && rst_q == S_STOP && rcnt == 4'h0;
    wire [4:0] rset   = {rdone && !rxd && rsh == 8'h00 && !rpar,
                         rdone && !rxd, rdone && rperr, rdone && lsr_f[0], rdone};
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_q <= S_IDLE;
            rcnt <= 4'h0;
            rbit <= 3'h0;
            rsh <= 8'h00;
            rbr <= 8'h00;
            rpar <= 1'b0;
            rperr <= 1'b0;
            rhigh <= 1'b1;
        end else if (mclr) begin
            rst_q <= S_IDLE;
        end else if (rtick) begin
            rcnt <= rcnt - 4'h1;
            rhigh <= rxd;
            case (rst_q)
                // Needs a mark tick first, so a long break starts no phantom character
                S_IDLE: if (!rxd && rhigh) begin
                    rst_q <= S_START;
                    rcnt <= `ASCE_RX_CONFIRM;
                end
                S_START: if (rxd) begin
                    rst_q <= S_IDLE;
                end else if (rcnt == 4'h0) begin
                    rst_q <= S_DATA;
                    rbit <= 3'h0;
                    rsh <= 8'h00;
                    rpar <= 1'b0;
                    rperr <= 1'b0;
                    rcnt <= 4'hf;
                end
                S_DATA: if (rcnt == 4'h0) begin
                    rsh[rbit] <= rxd;
                    rpar <= rpar ^ rxd;
                    rbit <= rbit + 3'h1;
                    rcnt <= 4'hf;
                    if (rbit == nbits)
                        rst_q <= lcr[`ASCE_LCR_PEN] ? S_PAR : S_STOP;
                end
                S_PAR: if (rcnt == 4'h0) begin
                    rperr <= rpar ^ rxd ^ !lcr[`ASCE_LCR_EPS];
                    rpar <= rxd;
                    rst_q <= S_STOP;
                    rcnt <= 4'hf;
                end
                S_STOP: if (rcnt == 4'h0) begin
                    rbr <= rsh;
                    rst_q <= S_IDLE;
                end
                default: rst_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // Status and interrupts
    // ****************************************
    reg [7:0] iir;
    wire      temt = !ff_valid && tst == S_IDLE;
    wire [7:0] lsr = {1'b0, temt, !ff_valid, lsr_f[4:1], lsr_f[0]};
    wire      irq_rls = ier[`ASCE_IER_RLS] && (|lsr_f[4:1]);
    wire      irq_rda = ier[`ASCE_IER_RDA] && lsr_f[0];
    wire      irq_thr = ier[`ASCE_IER_THRE] && thre_pend;
    always @* begin
        if (irq_rls)
            iir = 8'h06;
        else if (irq_rda)
            iir = 8'h04;
        else if (irq_thr)
            iir = 8'h02;
        else
            iir = `ASCE_RST_IIR;
    end
    assign o_irq_out = irq_rls || irq_rda || irq_thr;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            lsr_f <= 5'h00;
            thre_pend <= 1'b0;
        end else if (mclr) begin
            lsr_f <= 5'h00;
            thre_pend <= 1'b0;
        end else begin
            // Hardware set beats a read-clear in the same cycle
            lsr_f[0] <= rset[0] || (lsr_f[0] && !rb_rd);
            lsr_f[4:1] <= rset[4:1] | (lsr_f[4:1] & {4{!lsr_rd}});
            if (ff_valid && tpop && !thr_wr)
                thre_pend <= 1'b1;
            else if (thr_wr || (rd_go && addr == `ASCE_REG_IIR && iir == 8'h02))
                thre_pend <= 1'b0;
        end
    end

    // ****************************************
    // Read data path
    // ****************************************
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= 8'h00;
        end else if (rd_act) begin
            case (addr)
                `ASCE_REG_DATA: o_data <= divisor_access_bit ? divisor[7:0] : rbr;
                `ASCE_REG_IER: o_data <= divisor_access_bit ? divisor[15:8] : ier;
                `ASCE_REG_IIR: o_data <= iir;
                `ASCE_REG_LCR: o_data <= lcr;
                `ASCE_REG_MCR: o_data <= mcr;
                `ASCE_REG_LSR: o_data <= lsr;
                `ASCE_REG_MSR: o_data <= 8'h00;
                default: o_data <= scratch;
            endcase
        end
    end
    wire unused_ready = ff_ready;  // Writes to a full FIFO are dropped
endmodule
